// ==== rtl/rtcc_pkg.sv ====
// How it works
// - The month is two BCD digits, a one-bit tens and a four-bit units, and only 1 to 12 is ever held.
// - The day is a two-bit tens and four-bit units BCD pair from 1 to 31, 30, 28 or 29 by month and leap year.
// - The weekday is a three-bit count from 0x0 Sunday to 0x6 Saturday that wraps after seven.
// - The year is two four-bit BCD digits from 0 to 99, set and read by software.
// - A cause flag reads 1 once its event occurred; writing 1 clears it and writing 0 leaves it.
// - Regulation done sits at bit 15, stopwatch 1 Hz, 10 Hz and 100 Hz at bits 14, 13 and 12.
// - The alarm flag sits at bit 8 and the day to 1/32 second periodic flags at bits 7 down to 0.
// - Each enable bit matches its flag position; 1 lets the cause request, 0 blocks it.
`default_nettype none
package rtcc_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MONDAY  = 8'h00;
	localparam logic [7:0] OFS_YEARWK  = 8'h04;
	localparam logic [7:0] OFS_FLAGS   = 8'h08;
	localparam logic [7:0] OFS_ENABLES = 8'h0C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MON_TENS_POS  = 12;
	localparam int MON_UNITS_LSB = 8;
	localparam int DAY_TENS_LSB  = 4;
	localparam int DAY_UNITS_LSB = 0;
	localparam int WK_LSB        = 8;
	localparam int YR_TENS_LSB   = 4;
	localparam int YR_UNITS_LSB  = 0;

	// ------------------------------------------------------------
	// cause flag positions, shared by flags and enables
	// ------------------------------------------------------------
	localparam int FLAG_REGDONE = 15;
	localparam int FLAG_SW1HZ   = 14;
	localparam int FLAG_SW10HZ  = 13;
	localparam int FLAG_SW100HZ = 12;
	localparam int FLAG_ALARM   = 8;
	localparam int FLAG_PER_LSB = 0;
	localparam logic [15:0] FLAG_MASK = 16'hF1FF;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0]  MONTH_RST  = 8'h01;
	localparam logic [7:0]  DAY_RST    = 8'h01;
	localparam logic [2:0]  WK_RST     = 3'h0;
	localparam logic [7:0]  YEAR_RST   = 8'h00;
	localparam logic [15:0] FLAGS_RST  = 16'h0000;
	localparam logic [15:0] ENABLE_RST = 16'h0000;

	// ------------------------------------------------------------
	// calendar limits
	// ------------------------------------------------------------
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX  = 8'h99;
	localparam logic [2:0] WK_MAX    = 3'h6;

endpackage
`default_nettype wire

// ==== rtl/rtcc_flag_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// cause flag bank link between bus side and flag bank
interface rtcc_flag_if;
	logic [15:0] events;
	logic [15:0] clrMask;
	logic        enWrite;
	logic [15:0] enData;
	logic [15:0] flags;
	logic [15:0] enables;
	logic        irq;
	modport bus  (output events, clrMask, enWrite, enData, input flags, enables, irq);
	modport bank (input events, clrMask, enWrite, enData, output flags, enables, irq);
endinterface
`default_nettype wire

// ==== rtl/rtcc_flag_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcc_flag_bank (
	// clock and reset
	input wire logic    clk_sys,
	input wire logic    rstn,
	// bus side
	rtcc_flag_if.bank   fl
);

	// ------------------------------------------------------------
	// flag and enable storage
	// ------------------------------------------------------------
	logic [15:0] flags_ff;
	logic [15:0] enables_ff;
	logic        irq_ff;
	logic [15:0] nxt_flags;
	logic [15:0] nxt_enables;
	logic        nxt_irq;

	// set wins over clear so an event in the clear cycle survives
	assign nxt_flags   = ((flags_ff & ~fl.clrMask) | fl.events) & rtcc_pkg::FLAG_MASK;
	assign nxt_enables = fl.enWrite ? (fl.enData & rtcc_pkg::FLAG_MASK) : enables_ff;
	// request follows the next state so it lines up with the flags
	assign nxt_irq     = |(nxt_flags & nxt_enables);

	// state update
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			flags_ff   <= rtcc_pkg::FLAGS_RST;
			enables_ff <= rtcc_pkg::ENABLE_RST;
			irq_ff     <= 1'b0;
		end else begin
			flags_ff   <= nxt_flags;
			enables_ff <= nxt_enables;
			irq_ff     <= nxt_irq;
		end
	end

	assign fl.flags   = flags_ff;
	assign fl.enables = enables_ff;
	assign fl.irq     = irq_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_flag_sets: assert property (@(posedge clk_sys) disable iff (!rstn)
		(fl.events != 16'h0000) |=> ((flags_ff & $past(fl.events)) == $past(fl.events)))
		else $error("event did not set its flag");
	a_flag_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
		(fl.events == 16'h0000) |=> (flags_ff == ($past(flags_ff) & ~$past(fl.clrMask))))
		else $error("flag clear by one or hold by zero wrong");
	a_enable_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
		((flags_ff & enables_ff) == 16'h0000) |-> !irq_ff)
		else $error("request raised with no enabled flag");
	a_irq_any: assert property (@(posedge clk_sys) disable iff (!rstn)
		((flags_ff & enables_ff) != 16'h0000) |-> irq_ff)
		else $error("enabled flag did not request");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		((flags_ff | enables_ff) & ~rtcc_pkg::FLAG_MASK) == 16'h0000)
		else $error("reserved flag or enable bit set");

endmodule
`default_nettype wire

// ==== rtl/rtcc_top.sv ====
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rtcc_top #(
	parameter int ADR_W = 8,
	parameter int DAT_W = 32
) (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              rstn,
	// wishbone classic slave
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADR_W-1:0]  wb_adr_i,
	input wire logic [DAT_W/8-1:0] wb_sel_i,
	input wire logic [DAT_W-1:0]  wb_dat_i,
	output logic     [DAT_W-1:0]  wb_dat_o,
	output logic                  wb_ack_o,
	// carry from the hour counter
	input wire logic              dayCarry,
	// cause events, one-cycle pulses
	input wire logic              evRegDone,
	input wire logic [2:0]        evStopwatch,
	input wire logic              evAlarm,
	input wire logic [7:0]        evPeriodic,
	// interrupt request
	output logic                  irqReq
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (DAT_W != 32) begin : g_bad_width
		$error("rtcc_top serves only a 32-bit data bus");
	end
	if (ADR_W < 8) begin : g_bad_adr
		$error("rtcc_top needs at least 8 address bits");
	end

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// byte lanes to a 16-bit write mask
	function automatic logic [15:0] laneMask(input logic [DAT_W/8-1:0] sel);
		laneMask = {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// keep old bits outside the enabled lanes
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// two-digit bcd step; caller wraps the top digit
	function automatic logic [7:0] bcdInc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcdInc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcdInc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// both digits legal bcd
	function automatic logic bcdOk(input logic [7:0] v);
		bcdOk = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
	endfunction

	// last day of a month, leap when the bcd year divides by four
	function automatic logic [7:0] lastDay(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? ((yr[3:0] == 4'h2) || (yr[3:0] == 4'h6))
		             : ((yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8));
		if (mon == 8'h02) begin
			lastDay = leap ? 8'h29 : 8'h28;
		end else if ((mon == 8'h04) || (mon == 8'h06) || (mon == 8'h09) || (mon == 8'h11)) begin
			lastDay = 8'h30;
		end else begin
			lastDay = 8'h31;
		end
	endfunction

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic              ack_ff;
	logic [DAT_W-1:0]  rdat_ff;
	logic              busReq;
	logic              selMonDay;
	logic              selYearWk;
	logic              selFlags;
	logic              selEnables;
	logic              wrCommit;
	logic [15:0]       wrMask;
	logic [15:0]       wrData;

	// full address compare, so aliases answer zero
	assign busReq     = wb_cyc_i & wb_stb_i;
	assign selMonDay  = (wb_adr_i == ADR_W'(rtcc_pkg::OFS_MONDAY));
	assign selYearWk  = (wb_adr_i == ADR_W'(rtcc_pkg::OFS_YEARWK));
	assign selFlags   = (wb_adr_i == ADR_W'(rtcc_pkg::OFS_FLAGS));
	assign selEnables = (wb_adr_i == ADR_W'(rtcc_pkg::OFS_ENABLES));
	// writes land on the edge where the master sees ack
	assign wrCommit   = busReq & wb_we_i & ack_ff;
	assign wrMask     = laneMask(wb_sel_i);
	assign wrData     = wb_dat_i[15:0];

	// ------------------------------------------------------------
	// calendar counters
	// ------------------------------------------------------------
	logic [7:0]  month_ff;
	logic [7:0]  day_ff;
	logic [2:0]  wk_ff;
	logic [7:0]  year_ff;
	logic [7:0]  nxt_month;
	logic [7:0]  nxt_day;
	logic [2:0]  nxt_wk;
	logic [7:0]  nxt_year;
	logic [15:0] monDayView;
	logic [15:0] yearWkView;

	// packed register views, reserved bits zero
	assign monDayView = {3'h0, month_ff[4], month_ff[3:0], 2'h0, day_ff[5:4], day_ff[3:0]};
	assign yearWkView = {5'h00, wk_ff, year_ff[7:4], year_ff[3:0]};

	// write candidates after lane merging
	logic [15:0] monDayNew;
	logic [15:0] yearWkNew;
	logic [7:0]  wrMonth;
	logic [7:0]  wrDay;
	logic [2:0]  wrWk;
	logic [7:0]  wrYear;
	logic        monthOk;
	logic        dayOk;
	logic        wkOk;
	logic        yearOk;
	logic        wrMD;
	logic        wrYW;
	logic [7:0]  monthForDay;
	logic [7:0]  yearForDay;
	logic [7:0]  dayKept;
	logic        dateFits;
	logic        monthTake;
	logic        yearTake;

	assign wrMD      = wrCommit & selMonDay;
	assign wrYW      = wrCommit & selYearWk;
	assign monDayNew = merge(monDayView, wrData, wrMask);
	assign yearWkNew = merge(yearWkView, wrData, wrMask);
	assign wrMonth   = {3'h0, monDayNew[rtcc_pkg::MON_TENS_POS],
		monDayNew[rtcc_pkg::MON_UNITS_LSB +: 4]};
	assign wrDay     = {2'h0, monDayNew[rtcc_pkg::DAY_TENS_LSB +: 2],
		monDayNew[rtcc_pkg::DAY_UNITS_LSB +: 4]};
	assign wrWk      = yearWkNew[rtcc_pkg::WK_LSB +: 3];
	assign wrYear    = {yearWkNew[rtcc_pkg::YR_TENS_LSB +: 4],
		yearWkNew[rtcc_pkg::YR_UNITS_LSB +: 4]};

	// out-of-range values are dropped field by field, the rest still lands
	assign monthOk     = bcdOk(wrMonth) && (wrMonth >= 8'h01)
		&& (wrMonth <= rtcc_pkg::MONTH_MAX);
	assign monthForDay = (wrMD && monthOk) ? wrMonth : month_ff;
	assign yearForDay  = (wrYW && yearOk) ? wrYear : year_ff;
	assign dayOk       = bcdOk(wrDay) && (wrDay >= 8'h01)
		&& (wrDay <= lastDay(monthForDay, yearForDay));
	assign wkOk        = (wrWk <= rtcc_pkg::WK_MAX);
	assign yearOk      = bcdOk(wrYear);
	// a month or year that would strand the kept day is refused, so the
	// stored date never names a day that its month lacks unless dayCarry arrives in that same cycle
	assign dayKept     = (wrMD && dayOk) ? wrDay : day_ff;
	assign dateFits    = (dayKept <= lastDay(monthForDay, yearForDay));
	assign monthTake   = wrMD && monthOk && dateFits;
	assign yearTake    = wrYW && yearOk && dateFits;

	// carry chain on the day tick
	logic dayEnd;
	logic monEnd;
	logic [7:0] stepDay;
	logic [7:0] stepMonth;
	logic [7:0] stepYear;
	logic [2:0] stepWk;

	assign dayEnd    = (day_ff >= lastDay(month_ff, year_ff));
	assign monEnd    = (month_ff == rtcc_pkg::MONTH_MAX);
	assign stepDay   = dayEnd ? rtcc_pkg::DAY_RST : bcdInc(day_ff);
	assign stepMonth = !dayEnd ? month_ff : (monEnd ? rtcc_pkg::MONTH_RST : bcdInc(month_ff));
	assign stepYear  = !(dayEnd && monEnd) ? year_ff
		: ((year_ff == rtcc_pkg::YEAR_MAX) ? rtcc_pkg::YEAR_RST : bcdInc(year_ff));
	assign stepWk    = (wk_ff == rtcc_pkg::WK_MAX) ? 3'h0 : wk_ff + 3'h1;

	// a software write beats the carry for the field it hits
	assign nxt_month = monthTake ? wrMonth : (dayCarry ? stepMonth : month_ff);
	assign nxt_day   = (wrMD && dayOk) ? wrDay : (dayCarry ? stepDay : day_ff);
	assign nxt_wk    = (wrYW && wkOk) ? wrWk : (dayCarry ? stepWk : wk_ff);
	assign nxt_year  = yearTake ? wrYear : (dayCarry ? stepYear : year_ff);

	// calendar state
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			month_ff <= rtcc_pkg::MONTH_RST;
			day_ff   <= rtcc_pkg::DAY_RST;
			wk_ff    <= rtcc_pkg::WK_RST;
			year_ff  <= rtcc_pkg::YEAR_RST;
		end else begin
			month_ff <= nxt_month;
			day_ff   <= nxt_day;
			wk_ff    <= nxt_wk;
			year_ff  <= nxt_year;
		end
	end

	// ------------------------------------------------------------
	// cause flags and enables
	// ------------------------------------------------------------
	rtcc_flag_if flagLink ();

	// event positions fixed here, reserved lanes tied low
	assign flagLink.events = {evRegDone, evStopwatch[2], evStopwatch[1], evStopwatch[0],
		3'h0, evAlarm, evPeriodic};
	assign flagLink.clrMask = (wrCommit && selFlags) ? (wrData & wrMask) : 16'h0000;
	assign flagLink.enWrite = wrCommit & selEnables;
	assign flagLink.enData  = merge(flagLink.enables, wrData, wrMask);

	rtcc_flag_bank i_rtcc_flag_bank (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.fl      (flagLink)
	);

	assign irqReq = flagLink.irq;

	// ------------------------------------------------------------
	// read mux and answer
	// ------------------------------------------------------------
	logic [15:0]      rdLow;
	logic [DAT_W-1:0] nxt_rdat;
	logic             nxt_ack;

	// unmapped offsets read zero and still get ack
	assign rdLow = selMonDay  ? monDayView :
	               selYearWk  ? yearWkView :
	               selFlags   ? flagLink.flags :
	               selEnables ? flagLink.enables : 16'h0000;
	assign nxt_ack  = busReq & ~ack_ff;
	assign nxt_rdat = nxt_ack ? {{(DAT_W-16){1'b0}}, rdLow} : rdat_ff;

	// single-wait answer, ack drops the cycle after
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ack_ff  <= 1'b0;
			rdat_ff <= '0;
		end else begin
			ack_ff  <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_request;
		busReq && !ack_ff;
	endsequence
	sequence s_answer;
		ack_ff ##1 !ack_ff;
	endsequence

	a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_request |=> s_answer)
		else $error("bus answer not one wait then drop");
	a_month_range: assert property (@(posedge clk_sys) disable iff (!rstn)
		(month_ff >= 8'h01) && (month_ff <= 8'h12) && (month_ff[3:0] <= 4'h9))
		else $error("month left 1 to 12");
	a_day_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dayCarry && !wrMD && (day_ff == lastDay(month_ff, year_ff))) |=> (day_ff == 8'h01))
		else $error("day did not wrap to 1");
	a_day_range: assert property (@(posedge clk_sys) disable iff (!rstn)
		(day_ff >= 8'h01) && (day_ff <= lastDay(month_ff, year_ff)))
		else $error("day out of range");
	a_weekday_step: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dayCarry && !wrYW) |=> (wk_ff == (($past(wk_ff) == 3'h6) ? 3'h0 : $past(wk_ff) + 3'h1)))
		else $error("weekday did not step modulo seven");
	a_year_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dayCarry && !wrMD && !wrYW && (year_ff == 8'h99) && (month_ff == 8'h12)
			&& (day_ff == 8'h31)) |=> (year_ff == 8'h00) && (month_ff == 8'h01))
		else $error("year did not wrap at end of 99");
	a_year_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(yearTake && (wrMask[7:0] == 8'hFF)) |=> (year_ff == $past(wrData[7:0])))
		else $error("year write not taken");
	a_regdone_pos: assert property (@(posedge clk_sys) disable iff (!rstn)
		evRegDone |=> flagLink.flags[15])
		else $error("regulation done flag not at bit 15");
	a_alarm_pos: assert property (@(posedge clk_sys) disable iff (!rstn)
		evAlarm |=> flagLink.flags[8])
		else $error("alarm flag not at bit 8");
	a_read_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ack_ff && selFlags) |-> (wb_dat_o[31:16] == 16'h0000) && (wb_dat_o[11:9] == 3'h0))
		else $error("reserved flag bits read nonzero");
	a_reset_idle: assert property (@(posedge clk_sys)
		!rstn |=> (!wb_ack_o && (wb_dat_o == '0) && !irqReq))
		else $error("outputs not idle after reset");
	a_month_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		monthTake |=> (month_ff == $past(wrMonth)))
		else $error("legal month write not taken");
	a_month_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrMD && !monthTake && !dayCarry) |=> (month_ff == $past(month_ff)))
		else $error("refused month write changed the month");
	a_day_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrMD && dayOk) |=> (day_ff == $past(wrDay)))
		else $error("legal day write not taken");
	a_weekday_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrYW && wkOk) |=> (wk_ff == $past(wrWk)))
		else $error("legal weekday write not taken");
	a_weekday_range: assert property (@(posedge clk_sys) disable iff (!rstn)
		wk_ff <= rtcc_pkg::WK_MAX)
		else $error("weekday left 0 to 6");
	a_year_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrYW && !yearTake && !dayCarry) |=> (year_ff == $past(year_ff)))
		else $error("refused year write changed the year");
	a_year_range: assert property (@(posedge clk_sys) disable iff (!rstn)
		bcdOk(year_ff))
		else $error("year digit above 9");
	a_clear_by_one: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrCommit && selFlags && (flagLink.events == 16'h0000))
			|=> ((flagLink.flags & $past(wrData & wrMask)) == 16'h0000))
		else $error("flag written with one did not clear");
	a_irq_view: assert property (@(posedge clk_sys) disable iff (!rstn)
		irqReq == (|(flagLink.flags & flagLink.enables)))
		else $error("request differs from enabled flags");

	// every event lane checked on its own flag bit
	for (genvar g = 0; g < 3; g++) begin : g_stopwatch_chk
		a_stopwatch_pos: assert property (@(posedge clk_sys) disable iff (!rstn)
			evStopwatch[g] |=> flagLink.flags[rtcc_pkg::FLAG_SW100HZ + g])
			else $error("stopwatch flag not at its bit");
	end
	for (genvar g = 0; g < 8; g++) begin : g_periodic_chk
		a_periodic_pos: assert property (@(posedge clk_sys) disable iff (!rstn)
			evPeriodic[g] |=> flagLink.flags[rtcc_pkg::FLAG_PER_LSB + g])
			else $error("periodic flag not at its bit");
	end

endmodule
`default_nettype wire

// ==== testbench/tb_rtcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_rtcc_top;
	// ------------------------------------------------------------
	// bench signals
	// ------------------------------------------------------------
	logic        clk_sys     = 1'b0;
	logic        rstn        = 1'b0;
	logic        wbCyc       = 1'b0;
	logic        wbStb       = 1'b0;
	logic        wbWe        = 1'b0;
	logic [7:0]  wbAdr       = 8'h00;
	logic [3:0]  wbSel       = 4'h0;
	logic [31:0] wbDatI      = 32'h0000_0000;
	logic [31:0] wbDatO;
	logic        wbAck;
	logic        dayCarry    = 1'b0;
	logic        evRegDone   = 1'b0;
	logic [2:0]  evStopwatch = 3'h0;
	logic        evAlarm     = 1'b0;
	logic [7:0]  evPeriodic  = 8'h00;
	logic        irqReq;
	int          n_fail      = 0;
	int          cmp_count   = 0;

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	rtcc_top i_rtcc_top (
		.clk_sys     (clk_sys),
		.rstn        (rstn),
		.wb_cyc_i    (wbCyc),
		.wb_stb_i    (wbStb),
		.wb_we_i     (wbWe),
		.wb_adr_i    (wbAdr),
		.wb_sel_i    (wbSel),
		.wb_dat_i    (wbDatI),
		.wb_dat_o    (wbDatO),
		.wb_ack_o    (wbAck),
		.dayCarry    (dayCarry),
		.evRegDone   (evRegDone),
		.evStopwatch (evStopwatch),
		.evAlarm     (evAlarm),
		.evPeriodic  (evPeriodic),
		.irqReq      (irqReq)
	);

	// ------------------------------------------------------------
	// report and compare
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// ------------------------------------------------------------
	// wishbone classic single access
	// ------------------------------------------------------------
	// ack is read before the design's own updates land at that edge,
	// so the value seen is the one sampled there
	task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] dat,
			output logic [31:0] rd);
		int i;
		@(posedge clk_sys);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= adr;
		wbSel  <= 4'h3;
		wbDatI <= {16'h0000, dat};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (wbAck === 1'b1) break;
		end
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
		if (i == 20) begin
			n_fail++;
			$display("ERROR bus ack expected 1 seen timeout");
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
		logic [31:0] rd;
		bus(1'b1, adr, dat, rd);
	endtask

	task automatic rdchk(input string what, input logic [7:0] adr, input logic [15:0] exp);
		logic [31:0] rd;
		bus(1'b0, adr, 16'h0000, rd);
		check(what, rd, {16'h0000, exp});
	endtask

	// one-cycle event pulses laid out in flag register order
	task automatic pulse(input logic [15:0] m);
		@(posedge clk_sys);
		evRegDone   <= m[15];
		evStopwatch <= m[14:12];
		evAlarm     <= m[8];
		evPeriodic  <= m[7:0];
		@(posedge clk_sys);
		evRegDone   <= 1'b0;
		evStopwatch <= 3'h0;
		evAlarm     <= 1'b0;
		evPeriodic  <= 8'h00;
	endtask

	task automatic carry();
		@(posedge clk_sys);
		dayCarry <= 1'b1;
		@(posedge clk_sys);
		dayCarry <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdchk("month_day reset", rtcc_pkg::OFS_MONDAY, 16'h0101);
		rdchk("year_wk reset", rtcc_pkg::OFS_YEARWK, 16'h0000);
		rdchk("flags reset", rtcc_pkg::OFS_FLAGS, 16'h0000);
		rdchk("enables reset", rtcc_pkg::OFS_ENABLES, 16'h0000);
		rdchk("unmapped read", 8'h10, 16'h0000);
	endtask

	// invalid fields dropped, day judged against resulting month
	task automatic t_month_day();
		wr(rtcc_pkg::OFS_MONDAY, 16'h1231);
		rdchk("dec 31", rtcc_pkg::OFS_MONDAY, 16'h1231);
		wr(rtcc_pkg::OFS_MONDAY, 16'h1315);
		rdchk("month 13 dropped", rtcc_pkg::OFS_MONDAY, 16'h1215);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0010);
		rdchk("month 00 dropped", rtcc_pkg::OFS_MONDAY, 16'h1210);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0431);
		rdchk("apr 31 dropped", rtcc_pkg::OFS_MONDAY, 16'h0410);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0430);
		carry();
		rdchk("apr 30 rollover", rtcc_pkg::OFS_MONDAY, 16'h0501);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0229);
		rdchk("feb 29 leap", rtcc_pkg::OFS_MONDAY, 16'h0229);
		carry();
		rdchk("feb 29 rollover", rtcc_pkg::OFS_MONDAY, 16'h0301);
		wr(rtcc_pkg::OFS_YEARWK, 16'h0001);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0229);
		rdchk("feb 29 common", rtcc_pkg::OFS_MONDAY, 16'h0201);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0228);
		carry();
		rdchk("feb 28 rollover", rtcc_pkg::OFS_MONDAY, 16'h0301);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0331);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0431);
		rdchk("apr refused on 31", rtcc_pkg::OFS_MONDAY, 16'h0331);
		wr(rtcc_pkg::OFS_YEARWK, 16'h0004);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0229);
		wr(rtcc_pkg::OFS_YEARWK, 16'h0005);
		rdchk("year refused on feb 29", rtcc_pkg::OFS_YEARWK, 16'h0004);
		wr(rtcc_pkg::OFS_MONDAY, 16'h0301);
	endtask

	// year end wraps every counter at once
	task automatic t_year_week();
		wr(rtcc_pkg::OFS_YEARWK, 16'h0699);
		rdchk("sat year 99", rtcc_pkg::OFS_YEARWK, 16'h0699);
		wr(rtcc_pkg::OFS_YEARWK, 16'h07A0);
		rdchk("wk 7 digit A dropped", rtcc_pkg::OFS_YEARWK, 16'h0699);
		wr(rtcc_pkg::OFS_MONDAY, 16'h1231);
		carry();
		rdchk("new year date", rtcc_pkg::OFS_MONDAY, 16'h0101);
		rdchk("new year wrap", rtcc_pkg::OFS_YEARWK, 16'h0000);
		carry();
		rdchk("monday", rtcc_pkg::OFS_YEARWK, 16'h0100);
	endtask

	// each cause lands on its own bit; clear by one, zero leaves it
	task automatic t_flags();
		for (int b = 0; b < 16; b++) begin
			if (rtcc_pkg::FLAG_MASK[b]) begin
				wr(rtcc_pkg::OFS_FLAGS, 16'hFFFF);
				pulse(16'h0001 << b);
				rdchk("flag position", rtcc_pkg::OFS_FLAGS, 16'h0001 << b);
			end
		end
		pulse(16'hFFFF);
		rdchk("all flags", rtcc_pkg::OFS_FLAGS, 16'hF1FF);
		wr(rtcc_pkg::OFS_FLAGS, 16'h0000);
		rdchk("write 0 keeps", rtcc_pkg::OFS_FLAGS, 16'hF1FF);
		wr(rtcc_pkg::OFS_FLAGS, 16'h0101);
		rdchk("write 1 clears", rtcc_pkg::OFS_FLAGS, 16'hF0FE);
		wr(rtcc_pkg::OFS_FLAGS, 16'hFFFF);
		rdchk("all cleared", rtcc_pkg::OFS_FLAGS, 16'h0000);
	endtask

	// request follows flag and enable together
	task automatic t_irq();
		pulse(16'h0100);
		@(posedge clk_sys);
		check("irq masked", {31'h0, irqReq}, 32'h0000_0000);
		wr(rtcc_pkg::OFS_ENABLES, 16'hFFFF);
		rdchk("enables reserved", rtcc_pkg::OFS_ENABLES, 16'hF1FF);
		check("irq enabled", {31'h0, irqReq}, 32'h0000_0001);
		wr(rtcc_pkg::OFS_ENABLES, 16'hFEFF);
		@(posedge clk_sys);
		check("irq other enables", {31'h0, irqReq}, 32'h0000_0000);
		wr(rtcc_pkg::OFS_ENABLES, 16'h0100);
		@(posedge clk_sys);
		check("irq alarm only", {31'h0, irqReq}, 32'h0000_0001);
		wr(rtcc_pkg::OFS_FLAGS, 16'h0100);
		@(posedge clk_sys);
		check("irq after clear", {31'h0, irqReq}, 32'h0000_0000);
		wr(8'h20, 16'hFFFF);
		rdchk("unmapped write", rtcc_pkg::OFS_ENABLES, 16'h0100);
	endtask

	// reset in mid-run returns every register and the request to idle
	task automatic t_rerun();
		wr(rtcc_pkg::OFS_MONDAY, 16'h0715);
		pulse(16'h0100);
		@(posedge clk_sys);
		check("irq before reset", {31'h0, irqReq}, 32'h0000_0001);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		check("irq in reset", {31'h0, irqReq}, 32'h0000_0000);
		t_reset();
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_month_day();
		t_year_week();
		t_flags();
		t_irq();
		t_rerun();
		complete_run();
	end
endmodule
`default_nettype wire
